/* frame_fmt_consts.svh */
// offsets, field positions, reset values and masks of the frame format block
`ifndef FRAME_FMT_CONSTS_SVH
`define FRAME_FMT_CONSTS_SVH

`define CTRL0_OFFSET 8'h00
`define FRAME_FMT_OFFSET 8'h20
`define STATUS_OFFSET 8'h40

`define CTRL0_RESET 8'h00
`define FRAME_FMT_RESET 16'h0000
`define CTRL0_MASK 8'hE1
`define FRAME_FMT_MASK 16'hF1F7

`define CTRL0_PW 7
`define CTRL0_TXE 6
`define CTRL0_RXE 5
`define CTRL0_SLDC 0

`define FF_SLBM 15
`define FF_BLG_HI 14
`define FF_BLG_LO 12
`define FF_CLG 8
`define FF_SLP_HI 7
`define FF_SLP_LO 6
`define FF_TDL 5
`define FF_RDL 4
`define FF_SLG 2
`define FF_SLD 1
`define FF_SLIT 0

`define ST_BREAK_ACTIVE 0
`define ST_PARITY_ERR 1

`define BREAK_CODE_LONG_MAX 3'h4
`define BREAK_LEN_LONG 5'h10
`define BREAK_LEN_SHORT 5'h08

`endif

/* frame_fmt_pkg.sv */
// types and shared decoding of the frame format block
package frame_fmt_pkg;
   `include "frame_fmt_consts.svh"

   typedef enum logic [1:0] {
      PAR_NONE,
      PAR_SPACE,
      PAR_ODD,
      PAR_EVEN
   } parity_mode_type;

   typedef struct packed {
      logic char8;
      parity_mode_type parity;
      logic stop_len;
      logic msb_first;
      logic irq_timing;
      logic level_inv;
   } frame_cfg_type;

   typedef enum logic {BRK_IDLE, BRK_SEND} break_state_type;

   function automatic logic [4:0] break_bits(input logic [2:0] code);
      if (code <= `BREAK_CODE_LONG_MAX) begin
         return `BREAK_LEN_LONG + {2'b00, code};
      end
      return `BREAK_LEN_SHORT + {2'b00, code};
   endfunction : break_bits
endpackage : frame_fmt_pkg

/* break_field_gen.sv */
// break field generator: holds the line low for the selected bit count
`timescale 1ns/1ps
`include "frame_fmt_consts.svh"
module break_field_gen (
   input logic core_clk,
   input logic srst,
   input logic enable,
   input logic start,
   input logic bit_tick,
   input logic [2:0] length_code,
   output logic active,
   output logic done
);
   import frame_fmt_pkg::*;
   break_state_type state_reg, state_next;
   logic [4:0] count_reg, count_next;
   logic [4:0] len_reg, len_next;
   logic done_reg, done_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      len_next = len_reg;
      done_next = 1'b0;
      unique case (state_reg)
         BRK_IDLE: begin
            if (enable && start) begin
               state_next = BRK_SEND;
               count_next = 5'h00;
               len_next = break_bits(length_code);
            end
         end
         BRK_SEND: begin
            if (!enable) begin
               state_next = BRK_IDLE;
            end else if (bit_tick) begin
               if (count_reg == len_reg - 5'h01) begin
                  state_next = BRK_IDLE;
                  done_next = 1'b1;
               end else begin
                  count_next = count_reg + 5'h01;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= BRK_IDLE;
         count_reg <= 5'h00;
         len_reg <= 5'h00;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         len_reg <= len_next;
         done_reg <= done_next;
      end
   end

   assign active = (state_reg == BRK_SEND);
   assign done = done_reg;
endmodule : break_field_gen

/* parity_unit.sv */
// parity generation for transmit and parity check for receive
`timescale 1ns/1ps
`include "frame_fmt_consts.svh"
module parity_unit (
   input logic core_clk,
   input logic srst,
   input frame_fmt_pkg::frame_cfg_type tx_cfg,
   input frame_fmt_pkg::frame_cfg_type rx_cfg,
   input logic [7:0] tx_char,
   input logic [7:0] rx_char,
   input logic rx_parity_in,
   input logic rx_char_valid,
   output logic tx_parity_bit,
   output logic rx_parity_err
);
   import frame_fmt_pkg::*;
   logic tx_par_reg, tx_par_next;
   logic rx_err_reg, rx_err_next;

   function automatic logic par_of(input frame_cfg_type cfg,
                                   input logic [7:0] data);
      logic [7:0] used;
      used = cfg.char8 ? data : {1'b0, data[6:0]};
      unique case (cfg.parity)
         PAR_NONE: return 1'b0;
         PAR_SPACE: return 1'b0;
         PAR_ODD: return ~^used;
         PAR_EVEN: return ^used;
      endcase
   endfunction : par_of

   always_comb begin
      tx_par_next = par_of(tx_cfg, tx_char);
      rx_err_next = 1'b0;
      if (rx_char_valid && (rx_cfg.parity == PAR_ODD ||
          rx_cfg.parity == PAR_EVEN)) begin
         rx_err_next = (rx_parity_in != par_of(rx_cfg, rx_char));
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_par_reg <= 1'b0;
         rx_err_reg <= 1'b0;
      end else begin
         tx_par_reg <= tx_par_next;
         rx_err_reg <= rx_err_next;
      end
   end

   assign tx_parity_bit = tx_par_reg;
   assign rx_parity_err = rx_err_reg;
endmodule : parity_unit

/* uart_frame_format_control.sv */
// frame format control with wishbone register slave
// Function
// - bit 15 set enables break reception during data reception, clear disables.
// - with that enabled, receive uses 8 data bits and no parity.
// - break length code 101..100 gives 13 to 20 bit times.
// - length select 0 gives 7 data bits, 1 gives 8, for transmit, and for receive while bit 15 is clear.
// - frame format register is 16-bit wide; unused bits read zero.
// - parity field selects none, space, odd checked or even checked.
// - transmit invert flips the line at once, whatever the enables.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "frame_fmt_consts.svh"
module uart_frame_format_control (
   input logic core_clk,
   input logic srst,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [31:0] wb_dat_i,
   input logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input logic tx_serial_in,
   input logic break_start,
   input logic bit_tick,
   input logic [7:0] tx_char,
   input logic [7:0] rx_char,
   input logic rx_parity_in,
   input logic rx_char_valid,
   output logic txd,
   output frame_fmt_pkg::frame_cfg_type tx_cfg,
   output frame_fmt_pkg::frame_cfg_type rx_cfg,
   output logic [4:0] tx_break_len,
   output logic break_rx_during_data_en,
   output logic tx_parity_bit,
   output logic rx_parity_err,
   output logic break_active,
   output logic break_done,
   output logic unit_power_en,
   output logic tx_enable,
   output logic rx_enable
);
   import frame_fmt_pkg::*;

   logic [7:0] ctrl0_reg, ctrl0_next;
   logic [15:0] ffc_reg, ffc_next;
   logic [1:0] status_reg, status_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic txd_reg, txd_next;
   frame_cfg_type tx_cfg_reg, tx_cfg_next;
   frame_cfg_type rx_cfg_reg, rx_cfg_next;
   logic [4:0] blen_reg, blen_next;
   logic req;
   logic wr_req;
   logic rd_req;
   logic tx_on;
   logic rx_on;
   logic brk_active;
   logic par_err;

   // word-aligned address match
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] off);
      return adr[7:2] == off[7:2];
   endfunction : hit

   // frame settings for one direction
   function automatic frame_cfg_type cfg_of(input logic [15:0] ffc,
                                            input logic rx_side);
      frame_cfg_type c;
      c.char8 = ffc[`FF_CLG];
      c.parity = parity_mode_type'(ffc[`FF_SLP_HI:`FF_SLP_LO]);
      c.stop_len = ffc[`FF_SLG];
      c.msb_first = ffc[`FF_SLD];
      c.irq_timing = ffc[`FF_SLIT];
      c.level_inv = rx_side ? ffc[`FF_RDL] : ffc[`FF_TDL];
      if (rx_side && ffc[`FF_SLBM]) begin
         c.char8 = 1'b1;
         c.parity = PAR_NONE;
      end
      return c;
   endfunction : cfg_of

   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_req = req && wb_we_i;
   assign rd_req = req && !wb_we_i;
   assign tx_on = ctrl0_reg[`CTRL0_PW] && ctrl0_reg[`CTRL0_TXE];
   assign rx_on = ctrl0_reg[`CTRL0_PW] && ctrl0_reg[`CTRL0_RXE];

   // register writes and read data
   always_comb begin
      ctrl0_next = ctrl0_reg;
      ffc_next = ffc_reg;
      ack_next = req;
      rdata_next = rdata_reg;
      if (wr_req && hit(wb_adr_i, `CTRL0_OFFSET) && wb_sel_i[0]) begin
         ctrl0_next = wb_dat_i[7:0] & `CTRL0_MASK;
      end
      if (wr_req && hit(wb_adr_i, `FRAME_FMT_OFFSET) &&
          wb_sel_i[1:0] == 2'b11) begin
         ffc_next = wb_dat_i[15:0] & `FRAME_FMT_MASK;
      end
      if (rd_req) begin
         rdata_next = 32'h0000_0000;
         if (hit(wb_adr_i, `CTRL0_OFFSET)) begin
            rdata_next = {24'h00_0000, ctrl0_reg};
         end else if (hit(wb_adr_i, `FRAME_FMT_OFFSET)) begin
            rdata_next = {16'h0000, ffc_reg & `FRAME_FMT_MASK};
         end else if (hit(wb_adr_i, `STATUS_OFFSET)) begin
            rdata_next[1:0] = status_reg;
         end
      end
   end

   // status: break busy and sticky parity error
   always_comb begin
      status_next = status_reg;
      status_next[`ST_BREAK_ACTIVE] = brk_active;
      if (wr_req && hit(wb_adr_i, `STATUS_OFFSET) && wb_sel_i[0] &&
          wb_dat_i[`ST_PARITY_ERR]) begin
         status_next[`ST_PARITY_ERR] = 1'b0;
      end
      if (par_err) begin
         status_next[`ST_PARITY_ERR] = 1'b1;
      end
   end

   // derived frame settings
   always_comb begin
      tx_cfg_next = cfg_of(ffc_next, 1'b0);
      rx_cfg_next = cfg_of(ffc_next, 1'b1);
      blen_next = break_bits(ffc_next[`FF_BLG_HI:`FF_BLG_LO]);
   end

   // transmit line level
   always_comb begin
      txd_next = 1'b1;
      if (tx_on) begin
         txd_next = brk_active ? 1'b0 : tx_serial_in;
      end
      txd_next = txd_next ^ ffc_reg[`FF_TDL];
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl0_reg <= `CTRL0_RESET;
         ffc_reg <= `FRAME_FMT_RESET;
         status_reg <= 2'b00;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         txd_reg <= 1'b1;
         tx_cfg_reg <= '0;
         rx_cfg_reg <= '0;
         blen_reg <= `BREAK_LEN_LONG;
      end else begin
         ctrl0_reg <= ctrl0_next;
         ffc_reg <= ffc_next;
         status_reg <= status_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         txd_reg <= txd_next;
         tx_cfg_reg <= tx_cfg_next;
         rx_cfg_reg <= rx_cfg_next;
         blen_reg <= blen_next;
      end
   end

   break_field_gen u_break (
      .core_clk(core_clk),
      .srst(srst),
      .enable(tx_on),
      .start(break_start),
      .bit_tick(bit_tick),
      .length_code(ffc_reg[`FF_BLG_HI:`FF_BLG_LO]),
      .active(brk_active),
      .done(break_done)
   );

   parity_unit u_parity (
      .core_clk(core_clk),
      .srst(srst),
      .tx_cfg(tx_cfg_reg),
      .rx_cfg(rx_cfg_reg),
      .tx_char(tx_char),
      .rx_char(rx_char),
      .rx_parity_in(rx_parity_in),
      .rx_char_valid(rx_char_valid && rx_on),
      .tx_parity_bit(tx_parity_bit),
      .rx_parity_err(par_err)
   );

   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;
   assign txd = txd_reg;
   assign tx_cfg = tx_cfg_reg;
   assign rx_cfg = rx_cfg_reg;
   assign tx_break_len = blen_reg;
   assign break_rx_during_data_en = ffc_reg[`FF_SLBM];
   assign rx_parity_err = par_err;
   assign break_active = brk_active;
   assign unit_power_en = ctrl0_reg[`CTRL0_PW];
   assign tx_enable = ctrl0_reg[`CTRL0_TXE];
   assign rx_enable = ctrl0_reg[`CTRL0_RXE];

   brk_rx_mode_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_req && hit(wb_adr_i, `FRAME_FMT_OFFSET) && wb_sel_i[1:0] == 2'b11
      |=> break_rx_during_data_en == $past(wb_dat_i[15]))
      else $error("break receive mode bit not taken from write");

   rx_force_fmt_a: assert property (
      @(posedge core_clk) disable iff (srst)
      break_rx_during_data_en |-> rx_cfg.char8 && rx_cfg.parity == PAR_NONE)
      else $error("receive format not forced to 8 bits no parity");

   brk_len_short_a: assert property (
      @(posedge core_clk) disable iff (srst)
      ffc_reg[14:12] == 3'h5 |-> tx_break_len == 5'h0D)
      else $error("break code 101 does not give 13 bits");

   brk_len_long_a: assert property (
      @(posedge core_clk) disable iff (srst)
      ffc_reg[14:12] == 3'h4 |-> tx_break_len == 5'h14)
      else $error("break code 100 does not give 20 bits");

   char_len_a: assert property (
      @(posedge core_clk) disable iff (srst)
      tx_cfg.char8 == ffc_reg[8] &&
      (ffc_reg[15] || rx_cfg.char8 == ffc_reg[8]))
      else $error("character length does not follow select bit");

   reg_read_zero_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wb_ack_o && !wb_we_i && hit(wb_adr_i, `FRAME_FMT_OFFSET)
      |-> (wb_dat_o & 32'hFFFF_0E08) == 32'h0000_0000)
      else $error("unused frame format bits read nonzero");

   bus_ack_a: assert property (
      @(posedge core_clk) disable iff (srst)
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not one cycle after request");

   parity_odd_a: assert property (
      @(posedge core_clk) disable iff (srst)
      tx_cfg.parity == PAR_ODD && tx_cfg.char8
      |=> tx_parity_bit == ~^$past(tx_char))
      else $error("odd parity bit wrong");

   parity_space_a: assert property (
      @(posedge core_clk) disable iff (srst)
      rx_char_valid && rx_cfg.parity == PAR_SPACE
      |=> !rx_parity_err)
      else $error("space parity was checked");

   tx_invert_a: assert property (
      @(posedge core_clk) disable iff (srst)
      ffc_reg[5] && !tx_on |=> !txd)
      else $error("idle line not inverted");

   brk_line_low_a: assert property (
      @(posedge core_clk) disable iff (srst)
      brk_active && tx_on |=> txd == $past(ffc_reg[`FF_TDL]))
      else $error("transmit line not low during break");

   rx_no_parity_a: assert property (
      @(posedge core_clk) disable iff (srst)
      rx_char_valid && break_rx_during_data_en |=> !rx_parity_err)
      else $error("parity checked while break receive mode on");

   parity_even_a: assert property (
      @(posedge core_clk) disable iff (srst)
      tx_cfg.parity == PAR_EVEN && tx_cfg.char8
      |=> tx_parity_bit == ^$past(tx_char))
      else $error("even parity bit wrong");

   parity_sticky_a: assert property (
      @(posedge core_clk) disable iff (srst)
      par_err |=> status_reg[`ST_PARITY_ERR])
      else $error("parity error not recorded in status");

   ffc_zero_bits_a: assert property (
      @(posedge core_clk) disable iff (srst)
      (ffc_reg & 16'h0E08) == 16'h0000)
      else $error("unused frame format bits stored");
endmodule : uart_frame_format_control

/* peer_node.sv */
// serial peer model: bit time ticks and received characters
`timescale 1ns/1ps
module peer_node (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic send,
   input wire logic [7:0] ch,
   input wire logic odd,
   input wire logic bad,
   output logic bit_tick,
   output logic [7:0] rx_char,
   output logic rx_parity_in,
   output logic rx_char_valid
);
   logic [1:0] div_reg;
   logic [7:0] last_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_reg <= 2'h0;
         last_reg <= 8'h00;
         bit_tick <= 1'b0;
         rx_char <= 8'hff;
         rx_parity_in <= 1'b1;
         rx_char_valid <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         bit_tick <= (div_reg == 2'h3);
         rx_char_valid <= send;
         if (send) begin
            last_reg <= ch;
            rx_char <= ch;
            // odd or even parity bit, flipped on request
            rx_parity_in <= (odd ? ~^ch : ^ch) ^ bad;
         end else begin
            rx_char <= ~last_reg;
            rx_parity_in <= ~rx_parity_in;
         end
      end
   end
endmodule : peer_node

/* testbench.sv */
// self-checking testbench of the frame format control block
`timescale 1ns/1ps
module testbench;
   import frame_fmt_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic [31:0] rdat;
   logic ack, start = 1'b0, snd = 1'b0, bad = 1'b0, odd = 1'b0;
   logic ser = 1'b1;
   logic bit_tick, txd, slbm, tx_par, perr, active, done;
   logic pw, txe, rxe, rxv, rxp;
   logic [7:0] tx_ch = 8'h00;
   logic [7:0] rx_ch;
   logic [4:0] blen_o;
   frame_cfg_type tx_cfg, rx_cfg;
   logic [31:0] rng = 32'h0000_09f7;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;

   always #12.5 core_clk = ~core_clk;

   uart_frame_format_control u_uart_frame_format_control (
      .core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_dat_o(rdat), .wb_ack_o(ack), .tx_serial_in(ser),
      .break_start(start), .bit_tick(bit_tick), .tx_char(tx_ch),
      .rx_char(rx_ch), .rx_parity_in(rxp), .rx_char_valid(rxv),
      .txd(txd), .tx_cfg(tx_cfg), .rx_cfg(rx_cfg), .tx_break_len(blen_o),
      .break_rx_during_data_en(slbm), .tx_parity_bit(tx_par),
      .rx_parity_err(perr), .break_active(active), .break_done(done),
      .unit_power_en(pw), .tx_enable(txe), .rx_enable(rxe));

   peer_node u_peer_node (
      .core_clk(core_clk), .srst(srst), .send(snd), .ch(tx_ch), .odd(odd),
      .bad(bad), .bit_tick(bit_tick), .rx_char(rx_ch),
      .rx_parity_in(rxp), .rx_char_valid(rxv));

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd

   function automatic logic [31:0] blen(input logic [2:0] c);
      return (c > 3'h4) ? 32'(c) + 32'd8 : 32'(c) + 32'd16;
   endfunction : blen

   task automatic test_done();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wb(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic w,
                     output logic [31:0] q);
      int t;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      t = 0;
      do begin
         @(posedge core_clk);
         t++;
      end while (ack !== 1'b1 && t < 40);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (t >= 40) chk(32'h0, 32'h1);
   endtask : wb

   // enables off before any format change
   task automatic cfg(input logic [31:0] f, input logic [31:0] c0);
      logic [31:0] q;
      wb(8'h00, 32'h0000_0000, 4'hf, 1'b1, q);
      wb(8'h20, f, 4'hf, 1'b1, q);
      wb(8'h00, c0, 4'hf, 1'b1, q);
   endtask : cfg

   task automatic brk(input logic [2:0] c);
      int n;
      int t;
      // eight data bits for break frames
      cfg({17'h0, c, 12'h100}, 32'h0000_00c0);
      chk({pw, txe, rxe}, 3'b110);
      @(posedge core_clk);
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      n = 0;
      t = 0;
      do begin
         @(posedge core_clk);
         t++;
         if (bit_tick && active) n++;
         if (t == 6) chk(txd, 1'b0);
      end while (done !== 1'b1 && t < 200);
      chk(n, blen(c));
   endtask : brk

   task automatic par(input logic [15:0] f, input logic b, input logic e);
      logic [31:0] q;
      logic [7:0] ch;
      logic p;
      q = rnd();
      ch = {1'b0, q[6:0]};
      p = (f[7:6] == 2'b10) ? ~^ch : (f[7:6] == 2'b11) ? ^ch : 1'b0;
      // reception off while bit 15 changes
      cfg({16'h0, f}, 32'h0000_00a0);
      @(posedge core_clk);
      snd <= 1'b1;
      bad <= b;
      odd <= (f[7:6] == 2'b10);
      tx_ch <= ch;
      @(posedge core_clk);
      snd <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(perr, e);
      chk(tx_par, p);
   endtask : par

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      logic [31:0] d;
      logic [31:0] q;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      wb(8'h20, 32'h0, 4'hf, 1'b0, q);
      chk(q, 32'h0);
      chk(blen_o, 32'd16);
      chk(txd, 1'b1);
      for (int c = 0; c < 8; c++) begin
         d = rnd();
         d[14:12] = c[2:0];
         wb(8'h20, d, 4'hf, 1'b1, q);
         wb(8'h20, 32'h0, 4'hf, 1'b0, q);
         chk(q, d & 32'h0000_f1f7);
         chk(blen_o, blen(c[2:0]));
         chk(slbm, d[15]);
         chk(tx_cfg.char8, d[8]);
         chk({tx_cfg.stop_len, tx_cfg.msb_first, tx_cfg.irq_timing,
              tx_cfg.level_inv, rx_cfg.level_inv}, {d[2:0], d[5:4]});
         chk(rx_cfg.char8, d[8] | d[15]);
         chk(tx_cfg.parity, d[7:6]);
         chk(rx_cfg.parity, d[15] ? 2'b00 : d[7:6]);
      end
      wb(8'h20, ~d, 4'h1, 1'b1, q);
      wb(8'h20, 32'h0, 4'hf, 1'b0, q);
      chk(q, d & 32'h0000_f1f7);
      wb(8'h60, 32'h0, 4'hf, 1'b0, q);
      chk(q, 32'h0);
      cfg(32'h0000_0020, 32'h0000_0000);
      @(posedge core_clk);
      chk(txd, 1'b0);
      cfg(32'h0000_0020, 32'h0000_00c0);
      q = rnd();
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         ser <= q[i];
         repeat (2) @(posedge core_clk);
         chk(txd, q[i] ^ 1'b1);
      end
      ser <= 1'b1;
      cfg(32'h0000_0000, 32'h0000_0000);
      @(posedge core_clk);
      chk(txd, 1'b1);
      brk(3'h5);
      brk(3'h4);
      brk(3'h0);
      par(16'h0180, 1'b0, 1'b0);
      par(16'h0180, 1'b1, 1'b1);
      par(16'h01c0, 1'b1, 1'b1);
      par(16'h0140, 1'b1, 1'b0);
      par(16'h8180, 1'b1, 1'b0);
      par(16'h0080, 1'b1, 1'b1);
      wb(8'h40, 32'h0, 4'hf, 1'b0, q);
      chk(q, 32'h0000_0002);
      wb(8'h40, 32'h0000_0002, 4'h1, 1'b1, q);
      wb(8'h40, 32'h0, 4'hf, 1'b0, q);
      chk(q, 32'h0);
      test_done();
   end
endmodule : testbench
